// *** hw/dsau_data_space.sv ***
// data space access unit: decode, byte lanes, traps, x and y paths
//
// Overview of operation
// - effective addresses are 16-bit byte addresses
// - top bit clear is memory, set window
// - reads outside implemented memory return zero
// - low byte even address, high odd
// - pointer steps 1 for byte, 2 word
// - byte read picks lane onto low byte
// - shared word decode, per-lane write enables
// - odd x word access raises address error trap; odd y fetch only drops y valid
// - misaligned read completes; misaligned write suppressed
// - byte load writes register low byte only
// - sign-extend and clear-upper-byte operations supported
// - register region 0x0000-0x07ff, unused reads zero
// - 13-bit direct field reaches near region
// - 16-bit direct or pointer reaches everything
// - separate read and write address generators
// - independent x and y generators and paths
// - x read bus serves all combined reads
// - y read path only for dual fetch
// - modulo x/y; bit-reverse x writes, or y writes with modulo also set
// - writes use combined space; fixed boundary
`timescale 1ns/1ns
`include "dsau_consts.svh"
module dsau_data_space (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // x read request
  input wire logic rd_en,
  input wire logic rd_byte,
  input wire logic rd_direct,
  input wire logic rd_near,
  input wire logic [15:0] rd_direct_addr,
  input wire logic [15:0] rd_pointer,
  input wire logic [2:0] rd_ptr_op,
  input wire logic dual_fetch_dsp_class,
  // y read request
  input wire logic [15:0] y_pointer,
  input wire logic [2:0] y_ptr_op,
  // write request
  input wire logic wr_en,
  input wire logic wr_byte,
  input wire logic wr_direct,
  input wire logic [15:0] wr_direct_addr,
  input wire logic [15:0] wr_pointer,
  input wire logic [2:0] wr_ptr_op,
  input wire logic wr_bit_reverse,
  input wire logic wr_modulo,
  input wire logic [15:0] wr_data,
  // working register lane update
  input wire logic wreg_load,
  input wire logic sign_extend_op,
  input wire logic clear_upper_byte_op,
  input wire logic [15:0] wreg_old,
  // instruction boundary
  input wire logic instr_done,
  input wire logic trap_ack,
  // results
  output logic [15:0] x_rd_data,
  output logic [15:0] y_rd_data,
  output logic y_rd_valid,
  output logic [15:0] rd_pointer_next,
  output logic [15:0] wr_pointer_next,
  output logic [15:0] y_pointer_next,
  output logic [15:0] wreg_new,
  output logic addr_error_trap,
  output logic wr_done,
  output logic mode_error
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // sizes fixed at build time
  logic [7:0] sfr_lo [0:`DSAU_SFR_WORDS-1];
  logic [7:0] sfr_hi [0:`DSAU_SFR_WORDS-1];
  logic [7:0] ram_lo [0:`DSAU_RAM_WORDS-1];
  logic [7:0] ram_hi [0:`DSAU_RAM_WORDS-1];
  logic [`DSAU_SFR_WORDS-1:0] sfr_seen_lo;
  logic [`DSAU_SFR_WORDS-1:0] sfr_seen_hi;
  dsau_pkg::dsau_state_t state;
  dsau_pkg::dsau_state_t next_state;
  logic trap_pending;

  // ------------------------------------------------------------
  // address generation
  // ------------------------------------------------------------
  // all addresses are 16-bit byte addresses
  wire logic [15:0] rd_src;
  wire logic [15:0] wr_src;
  wire logic [15:0] rd_ea;
  wire logic [15:0] wr_ea;
  wire logic [15:0] y_ea;
  wire logic rd_mis;
  wire logic wr_mis;
  wire logic y_mis;
  wire logic rd_sfr;
  wire logic rd_ram;
  wire logic rd_win;
  wire logic wr_sfr;
  wire logic wr_ram;
  wire logic y_sfr;
  wire logic y_ram;
  wire logic y_in_x;
  wire logic [15:0] near_addr;
  // near field is 13 bits wide
  assign near_addr = {3'h0, rd_direct_addr[12:0]};
  assign rd_src = rd_direct ? (rd_near ? near_addr : rd_direct_addr) :
    rd_pointer;
  assign wr_src = wr_direct ? wr_direct_addr : wr_pointer;

  dsau_addr_gen_unit u_rd_agu (
    .working_pointer_reg(rd_src),
    .ptr_op(rd_direct ? 3'(dsau_pkg::DSAU_PTR_HOLD) : rd_ptr_op),
    .is_byte(rd_byte),
    .effective_addr(rd_ea),
    .next_pointer(rd_pointer_next),
    .misaligned(rd_mis),
    .in_sfr(rd_sfr),
    .in_ram(rd_ram),
    .in_program_window_area(rd_win),
    .in_x_space()
  );
  dsau_addr_gen_unit u_wr_agu (
    .working_pointer_reg(wr_src),
    .ptr_op(wr_direct ? 3'(dsau_pkg::DSAU_PTR_HOLD) : wr_ptr_op),
    .is_byte(wr_byte),
    .effective_addr(wr_ea),
    .next_pointer(wr_pointer_next),
    .misaligned(wr_mis),
    .in_sfr(wr_sfr),
    .in_ram(wr_ram),
    .in_program_window_area(),
    .in_x_space()
  );
  dsau_addr_gen_unit u_y_agu (
    .working_pointer_reg(y_pointer),
    .ptr_op(y_ptr_op),
    .is_byte(1'b0),
    .effective_addr(y_ea),
    .next_pointer(y_pointer_next),
    .misaligned(y_mis),
    .in_sfr(y_sfr),
    .in_ram(y_ram),
    .in_program_window_area(),
    .in_x_space(y_in_x)
  );

  // ------------------------------------------------------------
  // word decode and read lanes
  // ------------------------------------------------------------
  wire logic [12:0] rd_ram_idx;
  wire logic [9:0] rd_sfr_idx;
  wire logic [12:0] wr_ram_idx;
  wire logic [9:0] wr_sfr_idx;
  wire logic [12:0] y_ram_idx;
  wire logic [9:0] y_sfr_idx;
  wire logic [15:0] rd_ram_off;
  wire logic [15:0] wr_ram_off;
  wire logic [15:0] y_ram_off;
  wire logic [15:0] rd_word;
  wire logic [15:0] y_word;
  wire logic [15:0] rd_sel;
  wire logic [15:0] rd_sfr_word;
  wire logic [15:0] y_sfr_word;
  assign rd_ram_off = rd_ea - `DSAU_RAM_BASE;
  assign wr_ram_off = wr_ea - `DSAU_RAM_BASE;
  assign y_ram_off = y_ea - `DSAU_RAM_BASE;
  assign rd_ram_idx = rd_ram_off[13:1];
  assign wr_ram_idx = wr_ram_off[13:1];
  assign y_ram_idx = y_ram_off[13:1];
  assign rd_sfr_idx = rd_ea[10:1];
  assign wr_sfr_idx = wr_ea[10:1];
  assign y_sfr_idx = y_ea[10:1];
  // low lane even, high lane odd
  assign rd_word = rd_win ? 16'h0000 : rd_sfr ? rd_sfr_word :
    rd_ram ? {ram_hi[rd_ram_idx], ram_lo[rd_ram_idx]} : 16'h0000;
  assign rd_sfr_word = {
    sfr_seen_hi[rd_sfr_idx] ? sfr_hi[rd_sfr_idx] : 8'h00,
    sfr_seen_lo[rd_sfr_idx] ? sfr_lo[rd_sfr_idx] : 8'h00};
  assign y_sfr_word = {
    sfr_seen_hi[y_sfr_idx] ? sfr_hi[y_sfr_idx] : 8'h00,
    sfr_seen_lo[y_sfr_idx] ? sfr_lo[y_sfr_idx] : 8'h00};
  assign y_word = y_sfr ? y_sfr_word :
    y_ram ? {ram_hi[y_ram_idx], ram_lo[y_ram_idx]} : 16'h0000;
  assign rd_sel = !rd_byte ? rd_word :
    rd_ea[0] ? {8'h00, rd_word[15:8]} : {8'h00, rd_word[7:0]};

  // ------------------------------------------------------------
  // write strobes
  // ------------------------------------------------------------
  wire logic wr_bad_mode;
  wire logic wr_ok;
  wire logic we_lo;
  wire logic we_hi;
  wire logic [7:0] wd_lo;
  wire logic [7:0] wd_hi;
  wire logic rd_mis_hit;
  wire logic wr_mis_hit;
  // bit-reverse for x space writes, or y space writes when modulo is also set
  assign wr_bad_mode = wr_en && wr_bit_reverse && !(wr_ea <
    `DSAU_XY_BOUNDARY) && !wr_modulo;
  assign wr_ok = wr_en && !wr_mis && !wr_bad_mode && !trap_pending;
  assign we_lo = wr_ok && (!wr_byte || !wr_ea[0]);
  assign we_hi = wr_ok && (!wr_byte || wr_ea[0]);
  assign wd_lo = wr_data[7:0];
  assign wd_hi = wr_byte ? wr_data[7:0] : wr_data[15:8];
  wire logic ram_we_lo;
  wire logic ram_we_hi;
  wire logic sfr_we_lo;
  wire logic sfr_we_hi;
  assign ram_we_lo = we_lo && wr_ram;
  assign ram_we_hi = we_hi && wr_ram;
  assign sfr_we_lo = we_lo && wr_sfr;
  assign sfr_we_hi = we_hi && wr_sfr;
  assign rd_mis_hit = rd_en && rd_mis;
  assign wr_mis_hit = wr_en && wr_mis;

  // ------------------------------------------------------------
  // working register lanes
  // ------------------------------------------------------------
  wire logic [15:0] next_wreg;
  assign next_wreg = sign_extend_op ? {{8{wreg_old[7]}}, wreg_old[7:0]} :
    clear_upper_byte_op ? {8'h00, wreg_old[7:0]} :
    (wreg_load && rd_byte) ? {wreg_old[15:8], rd_sel[7:0]} :
    wreg_load ? rd_sel : wreg_old;

  // ------------------------------------------------------------
  // trap sequencing
  // ------------------------------------------------------------
  // trap taken once instruction ends
  always_comb begin
    next_state = state;
    case (state)
      dsau_pkg::DSAU_ST_RUN: begin
        if ((trap_pending || rd_mis_hit || wr_mis_hit) && instr_done) begin
          next_state = dsau_pkg::DSAU_ST_TRAP;
        end
      end
      dsau_pkg::DSAU_ST_TRAP: begin
        if (trap_ack) begin
          next_state = dsau_pkg::DSAU_ST_RUN;
        end
      end
      default: next_state = dsau_pkg::DSAU_ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= dsau_pkg::DSAU_ST_RUN;
      trap_pending <= 1'b0;
    end else begin
      state <= next_state;
      // clear wins on instruction end; a same-cycle fault goes straight to the trap state
      if (rd_mis_hit || wr_mis_hit) begin
        trap_pending <= !instr_done;
      end else if (instr_done) begin
        trap_pending <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // memory writes
  // ------------------------------------------------------------
  // arrays carry no reset: too large, and contents are don't-care
  genvar gi;
  generate
    for (gi = 0; gi < 1; gi = gi + 1) begin : g_wr
      always_ff @(posedge ref_clk) begin
        if (ram_we_lo) begin
          ram_lo[wr_ram_idx] <= wd_lo;
        end
        if (ram_we_hi) begin
          ram_hi[wr_ram_idx] <= wd_hi;
        end
        if (sfr_we_lo) begin
          sfr_lo[wr_sfr_idx] <= wd_lo;
        end
        if (sfr_we_hi) begin
          sfr_hi[wr_sfr_idx] <= wd_hi;
        end
      end
    end
  endgenerate

  // marks keep unwritten register bytes at zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sfr_seen_lo <= '0;
      sfr_seen_hi <= '0;
    end else begin
      if (sfr_we_lo) begin
        sfr_seen_lo[wr_sfr_idx] <= 1'b1;
      end
      if (sfr_we_hi) begin
        sfr_seen_hi[wr_sfr_idx] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      x_rd_data <= 16'h0000;
      y_rd_data <= 16'h0000;
      y_rd_valid <= 1'b0;
      wreg_new <= 16'h0000;
      addr_error_trap <= 1'b0;
      wr_done <= 1'b0;
      mode_error <= 1'b0;
    end else begin
      // x read bus serves all reads
      if (rd_en) begin
        x_rd_data <= rd_sel;
      end
      // y path only for dual fetch
      y_rd_valid <= rd_en && dual_fetch_dsp_class && !y_mis;
      if (rd_en && dual_fetch_dsp_class) begin
        y_rd_data <= y_in_x ? 16'h0000 : y_word;
      end
      wreg_new <= next_wreg;
      addr_error_trap <= (next_state == dsau_pkg::DSAU_ST_TRAP);
      wr_done <= wr_ok;
      mode_error <= wr_bad_mode;
    end
  end
endmodule : dsau_data_space

// *** hw/dsau_consts.svh ***
// constants for the data space access unit
`ifndef DSAU_CONSTS_SVH
`define DSAU_CONSTS_SVH
`define DSAU_RAM_BYTES 16'h4000
`define DSAU_XY_BOUNDARY 16'h2800
`define DSAU_SFR_LAST 16'h07ff
`define DSAU_RAM_BASE 16'h0800
`define DSAU_NEAR_LAST 16'h1fff
`define DSAU_PROG_WIN_BIT 15
`define DSAU_STEP_BYTE 16'h0001
`define DSAU_STEP_WORD 16'h0002
`define DSAU_SFR_WORDS 1024
`define DSAU_RAM_WORDS 8192
`endif

// *** hw/dsau_pkg.sv ***
// types for the data space access unit
package dsau_pkg;
  typedef enum logic [2:0] {
    DSAU_REGION_SFR = 3'h1,
    DSAU_REGION_RAM = 3'h2,
    DSAU_REGION_NONE = 3'h4
  } dsau_region_t;
  typedef enum logic [2:0] {
    DSAU_PTR_HOLD = 3'h1,
    DSAU_PTR_INC = 3'h2,
    DSAU_PTR_DEC = 3'h4
  } dsau_ptr_op_t;
  typedef enum logic [1:0] {
    DSAU_ST_RUN = 2'h1,
    DSAU_ST_TRAP = 2'h2
  } dsau_state_t;
endpackage : dsau_pkg

// *** hw/dsau_addr_gen_unit.sv ***
// address generation unit: pointer post-modify and region decode
`timescale 1ns/1ns
`include "dsau_consts.svh"
module dsau_addr_gen_unit (
  // pointer and request
  input wire logic [15:0] working_pointer_reg,
  input wire logic [2:0] ptr_op,
  input wire logic is_byte,
  // results
  output logic [15:0] effective_addr,
  output logic [15:0] next_pointer,
  output logic misaligned,
  output logic in_sfr,
  output logic in_ram,
  output logic in_program_window_area,
  output logic in_x_space
);
  wire logic [15:0] step;
  wire logic [15:0] ram_end;
  assign step = is_byte ? `DSAU_STEP_BYTE : `DSAU_STEP_WORD;
  assign effective_addr = working_pointer_reg;
  assign next_pointer =
    (ptr_op == dsau_pkg::DSAU_PTR_INC) ? working_pointer_reg + step :
    (ptr_op == dsau_pkg::DSAU_PTR_DEC) ? working_pointer_reg - step :
    working_pointer_reg;
  assign misaligned = !is_byte && working_pointer_reg[0];
  assign in_program_window_area = working_pointer_reg[`DSAU_PROG_WIN_BIT];
  assign in_sfr = working_pointer_reg <= `DSAU_SFR_LAST;
  assign ram_end = `DSAU_RAM_BASE + `DSAU_RAM_BYTES;
  assign in_ram = !in_sfr && !in_program_window_area &&
    (working_pointer_reg < ram_end);
  assign in_x_space = working_pointer_reg < `DSAU_XY_BOUNDARY;
endmodule : dsau_addr_gen_unit

// *** bench/dsau_core_model.sv ***
// core-side model: takes the address error trap after a delay
`timescale 1ns/1ns
module dsau_core_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // trap handshake
  input wire logic addr_error_trap,
  input wire logic [3:0] ack_delay,
  output logic trap_ack
);
  logic [3:0] wait_cnt;
  // trap taken later
  // driven on the falling edge so the unit samples a settled pulse
  always @(negedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      trap_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (trap_ack || !addr_error_trap) begin
      trap_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (wait_cnt == ack_delay) begin
      trap_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : dsau_core_model

// *** bench/dsau_data_space_asserts.sv ***
// port assertions for the data space access unit
`timescale 1ns/1ns
module dsau_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // requests
  input wire logic rd_en,
  input wire logic rd_byte,
  input wire logic rd_direct,
  input wire logic [15:0] rd_pointer,
  input wire logic [2:0] rd_ptr_op,
  input wire logic dual_fetch_dsp_class,
  input wire logic wr_en,
  input wire logic wr_byte,
  input wire logic wr_direct,
  input wire logic [15:0] wr_pointer,
  input wire logic [2:0] wr_ptr_op,
  input wire logic instr_done,
  input wire logic trap_ack,
  // results
  input wire logic [15:0] x_rd_data,
  input wire logic y_rd_valid,
  input wire logic [15:0] rd_pointer_next,
  input wire logic [15:0] wr_pointer_next,
  input wire logic addr_error_trap,
  input wire logic wr_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_rd_ptr_step:
    assert property (rd_en && !rd_direct && rd_ptr_op ==
      dsau_pkg::DSAU_PTR_INC |-> rd_pointer_next == rd_pointer +
      (rd_byte ? 16'h0001 : 16'h0002)) else $error("read step wrong");
  a_wr_ptr_step:
    assert property (wr_en && !wr_direct && wr_ptr_op ==
      dsau_pkg::DSAU_PTR_DEC |-> wr_pointer_next == wr_pointer -
      (wr_byte ? 16'h0001 : 16'h0002)) else $error("write step wrong");
  a_window_zero:
    assert property (rd_en && !rd_direct && rd_pointer[15] |=>
      x_rd_data == 16'h0000) else $error("window read not zero");
  a_byte_lane:
    assert property (rd_en && rd_byte |=> x_rd_data[15:8] == 8'h00)
    else $error("byte read high lane set");
  a_odd_wr_drop:
    assert property (wr_en && !wr_byte && !wr_direct && wr_pointer[0]
      |=> !wr_done) else $error("odd word write committed");
  a_trap_cause:
    assert property ($rose(addr_error_trap) |-> $past(instr_done))
    else $error("trap before instruction end");
  a_trap_holds:
    assert property (addr_error_trap && !trap_ack |=> addr_error_trap)
    else $error("trap dropped unacknowledged");
  a_y_dual_only:
    assert property (y_rd_valid |-> $past(dual_fetch_dsp_class))
    else $error("y read without dual fetch");
endmodule : dsau_checker
bind dsau_data_space dsau_checker u_chk (.ref_clk, .nrst, .rd_en,
  .rd_byte, .rd_direct, .rd_pointer, .rd_ptr_op, .dual_fetch_dsp_class,
  .wr_en, .wr_byte, .wr_direct, .wr_pointer, .wr_ptr_op, .instr_done,
  .trap_ack, .x_rd_data, .y_rd_valid, .rd_pointer_next, .wr_pointer_next,
  .addr_error_trap, .wr_done);

// *** bench/test_data_space_access_unit.sv ***
// self-checking bench for the data space access unit
`timescale 1ns/1ns
module test_data_space_access_unit;
  logic ref_clk, nrst, rd_en, rd_byte, rd_direct, rd_near, wr_en, wr_byte;
  logic dual_fetch_dsp_class, wr_direct, wr_bit_reverse, wr_modulo;
  logic wreg_load, sign_extend_op, clear_upper_byte_op, instr_done;
  logic trap_ack, y_rd_valid, addr_error_trap, wr_done, mode_error;
  logic [15:0] rd_direct_addr, rd_pointer, y_pointer, wr_direct_addr;
  logic [15:0] wr_pointer, wr_data, wreg_old, x_rd_data, y_rd_data;
  logic [15:0] rd_pointer_next, wr_pointer_next, y_pointer_next, wreg_new;
  logic [2:0] rd_ptr_op, y_ptr_op, wr_ptr_op;
  logic [3:0] ack_delay;
  int mismatches, total_checks;
  dsau_data_space DUT (.ref_clk, .nrst, .rd_en, .rd_byte, .rd_direct,
    .rd_near, .rd_direct_addr, .rd_pointer, .rd_ptr_op,
    .dual_fetch_dsp_class, .y_pointer, .y_ptr_op, .wr_en, .wr_byte,
    .wr_direct, .wr_direct_addr, .wr_pointer, .wr_ptr_op, .wr_bit_reverse,
    .wr_modulo, .wr_data, .wreg_load, .sign_extend_op, .clear_upper_byte_op,
    .wreg_old, .instr_done, .trap_ack, .x_rd_data, .y_rd_data, .y_rd_valid,
    .rd_pointer_next, .wr_pointer_next, .y_pointer_next, .wreg_new,
    .addr_error_trap, .wr_done, .mode_error);
  dsau_core_model core (.ref_clk, .nrst, .addr_error_trap, .ack_delay,
    .trap_ack);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ----
  // shared tasks
  // ----
  task automatic chk(input string n, input logic [15:0] e, g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, d, input logic b, output logic ok);
    @(negedge ref_clk);
    wr_en = 1'b1;
    wr_pointer = a;
    wr_data = d;
    wr_byte = b;
    @(negedge ref_clk);
    ok = wr_done;
    wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic b, output logic [15:0] q);
    @(negedge ref_clk);
    rd_en = 1'b1;
    rd_pointer = a;
    rd_byte = b;
    @(negedge ref_clk);
    q = x_rd_data;
    rd_en = 1'b0;
  endtask : rd
  // ends the faulting instruction; trap must stay until taken
  task automatic end_instr;
    logic ok;
    logic [15:0] q;
    wr(16'h0802, 16'h9999, 1'b0, ok);
    chk("write pending", 16'h0000, 16'(ok));
    @(negedge ref_clk);
    instr_done = 1'b1;
    @(negedge ref_clk);
    instr_done = 1'b0;
    chk("trap", 16'h0001, 16'(addr_error_trap));
    for (int i = 0; i < 20 && addr_error_trap !== 1'b0; i++)
      @(negedge ref_clk);
    chk("trap clear", 16'h0000, 16'(addr_error_trap));
    rd(16'h0802, 1'b0, q);
    chk("kept word", 16'h1234, q);
  endtask : end_instr
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // ----
  // scenarios
  // ----
  task automatic t_lanes;
    logic ok;
    logic [15:0] q;
    wr(16'h0800, 16'ha55a, 1'b0, ok);
    chk("wr_done", 16'h0001, 16'(ok));
    rd(16'h0800, 1'b1, q);
    chk("low byte", 16'h005a, q);
    rd(16'h0801, 1'b1, q);
    chk("high byte", 16'h00a5, q);
    wr(16'h0801, 16'h0033, 1'b1, ok);
    rd(16'h0800, 1'b0, q);
    chk("byte lane", 16'h335a, q);
    $display("lanes test done");
  endtask : t_lanes
  task automatic t_space;
    logic ok;
    logic [15:0] q;
    wr(16'h4800, 16'hffff, 1'b0, ok);
    rd(16'h4800, 1'b0, q);
    chk("beyond ram", 16'h0000, q);
    rd(16'h8800, 1'b0, q);
    chk("window", 16'h0000, q);
    rd(16'h0100, 1'b0, q);
    chk("unused register", 16'h0000, q);
    wr(16'h0100, 16'h00c3, 1'b1, ok);
    rd(16'h0100, 1'b0, q);
    chk("half register", 16'h00c3, q);
    rd_direct = 1'b1;
    rd_near = 1'b1;
    rd_direct_addr = 16'he800;
    rd(16'h0000, 1'b0, q);
    chk("near", 16'h335a, q);
    rd_near = 1'b0;
    rd_direct_addr = 16'h0800;
    rd(16'h0000, 1'b0, q);
    chk("direct", 16'h335a, q);
    rd_direct = 1'b0;
    $display("space test done");
  endtask : t_space
  task automatic t_trap;
    logic ok;
    logic [15:0] q;
    ack_delay = 4'h3;
    wr(16'h0802, 16'h1234, 1'b0, ok);
    wr(16'h0803, 16'hbeef, 1'b0, ok);
    chk("odd write", 16'h0000, 16'(ok));
    chk("trap early", 16'h0000, 16'(addr_error_trap));
    end_instr();
    ack_delay = 4'h9;
    rd(16'h0803, 1'b0, q);
    end_instr();
    $display("trap test done");
  endtask : t_trap
  task automatic t_ptr;
    logic [15:0] s, e;
    for (int i = 0; i < 4; i++) begin
      @(negedge ref_clk);
      s = i[0] ? 16'h0001 : 16'h0002;
      e = i[1] ? 16'h0a00 - s : 16'h0a00 + s;
      {rd_en, wr_en, dual_fetch_dsp_class} = 3'h7;
      rd_byte = i[0];
      wr_byte = i[0];
      rd_ptr_op = i[1] ? dsau_pkg::DSAU_PTR_DEC : dsau_pkg::DSAU_PTR_INC;
      wr_ptr_op = rd_ptr_op;
      y_ptr_op = rd_ptr_op;
      {rd_pointer, wr_pointer, y_pointer} = {16'h0a00, 16'h0a00, 16'h2a00};
      #1;
      chk("rd step", e, rd_pointer_next);
      chk("wr step", e, wr_pointer_next);
      chk("y step", i[1] ? 16'h29fe : 16'h2a02, y_pointer_next);
    end
    @(negedge ref_clk);
    {rd_en, wr_en, dual_fetch_dsp_class} = 3'h0;
    {rd_ptr_op, wr_ptr_op, y_ptr_op} = {3{dsau_pkg::DSAU_PTR_HOLD}};
    $display("pointer test done");
  endtask : t_ptr
  task automatic t_dual;
    logic ok;
    logic [15:0] q;
    wr(16'h2a00, 16'h7e81, 1'b0, ok);
    wr(16'h0a04, 16'h1111, 1'b0, ok);
    @(negedge ref_clk);
    {rd_en, dual_fetch_dsp_class, rd_byte} = 3'h6;
    {rd_pointer, y_pointer} = {16'h0a04, 16'h2a00};
    @(negedge ref_clk);
    {rd_en, dual_fetch_dsp_class} = 2'h0;
    chk("x data", 16'h1111, x_rd_data);
    chk("y data", 16'h7e81, y_rd_data);
    chk("y valid", 16'h0001, 16'(y_rd_valid));
    rd(16'h0a04, 1'b0, q);
    chk("y idle", 16'h0000, 16'(y_rd_valid));
    wr_bit_reverse = 1'b1;
    wr(16'h2a00, 16'h5555, 1'b0, ok);
    chk("mode error", 16'h0001, 16'(mode_error));
    chk("y reversed", 16'h0000, 16'(ok));
    wr(16'h0a06, 16'h5555, 1'b0, ok);
    chk("x reversed", 16'h0001, 16'(ok));
    wr_bit_reverse = 1'b0;
    wr_modulo = 1'b1;
    wr(16'h2a02, 16'h5555, 1'b0, ok);
    chk("y modulo", 16'h0001, 16'(ok));
    wr_modulo = 1'b0;
    $display("dual test done");
  endtask : t_dual
  task automatic t_wreg;
    @(negedge ref_clk);
    wreg_old = 16'h3485;
    sign_extend_op = 1'b1;
    @(negedge ref_clk);
    chk("sign extend", 16'hff85, wreg_new);
    {sign_extend_op, clear_upper_byte_op} = 2'h1;
    @(negedge ref_clk);
    chk("clear upper", 16'h0085, wreg_new);
    {clear_upper_byte_op, wreg_load} = 2'h1;
    rd_byte = 1'b1;
    rd_pointer = 16'h2a01;
    @(negedge ref_clk);
    chk("byte load", 16'h347e, wreg_new);
    wreg_load = 1'b0;
    $display("wreg test done");
  endtask : t_wreg
  // ----
  // run
  // ----
  initial begin
    {nrst, rd_en, rd_byte, rd_direct, rd_near, dual_fetch_dsp_class, wr_en,
      wr_byte, wr_direct, wr_bit_reverse, wr_modulo, wreg_load,
      sign_extend_op, clear_upper_byte_op, instr_done} = '0;
    {rd_direct_addr, rd_pointer, y_pointer, wr_direct_addr, wr_pointer,
      wr_data, wreg_old} = '0;
    {rd_ptr_op, y_ptr_op, wr_ptr_op} = {3{dsau_pkg::DSAU_PTR_HOLD}};
    ack_delay = 4'h0;
    repeat (20) @(negedge ref_clk);
    nrst = 1'b1;
    t_lanes();
    t_space();
    t_trap();
    t_ptr();
    t_dual();
    t_wreg();
    tally_and_finish();
  end
  // tests need under 150 cycles; generous margin for a hang
  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    tally_and_finish();
  end
endmodule : test_data_space_access_unit
